/* File: verilog/vtm_pkg.sv */
// Shared constants and types of the input-voltage and temperature monitor
package vtm_pkg;

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_INPUT_TURN_OFF_THRESHOLD = 8'h36;
  localparam logic [7:0] CMD_OT_FAULT = 8'h4F;
  localparam logic [7:0] CMD_OT_WARN = 8'h51;
  localparam logic [7:0] CMD_VIN_OV_FAULT = 8'h55;
  localparam logic [7:0] CMD_VIN_OV_WARN = 8'h57;
  localparam logic [7:0] CMD_VIN_UV_WARN = 8'h58;

  // ---------------------------------------------------------------
  // Limit storage: index, field width and reset value
  // ---------------------------------------------------------------
  localparam int LIM_NUM = 6;
  localparam logic [2:0] IDX_INPUT_TURN_OFF_THRESHOLD = 3'h0;
  localparam logic [2:0] IDX_OT_FAULT = 3'h1;
  localparam logic [2:0] IDX_OT_WARN = 3'h2;
  localparam logic [2:0] IDX_OV_FAULT = 3'h3;
  localparam logic [2:0] IDX_OV_WARN = 3'h4;
  localparam logic [2:0] IDX_UV_WARN = 3'h5;
  localparam logic [2:0] IDX_NONE = 3'h7;
  localparam logic [7:0] MASK_VOLT = 8'h3F;
  localparam logic [7:0] MASK_TEMP = 8'hFF;
  localparam logic [LIM_NUM-1:0][7:0] RST_LIMS =
    {8'h28, 8'h1E, 8'h20, 8'h8C, 8'h91, 8'h0B};
  localparam int OP_ON_BIT = 7;
  localparam logic OP_ON_RST = 1'b1;

  // ---------------------------------------------------------------
  // Conditions and sticky flags
  // ---------------------------------------------------------------
  localparam int NFLAG = 5;
  localparam int NCOND = 6;
  localparam int FLG_OT_FAULT = 0;
  localparam int FLG_OT_WARN = 1;
  localparam int FLG_OV_FAULT = 2;
  localparam int FLG_OV_WARN = 3;
  localparam int FLG_UV_WARN = 4;
  localparam int CND_VIN_LOW = 5;
  localparam logic [NFLAG-1:0] ALERT_MASK = 5'h1B;

  // ---------------------------------------------------------------
  // Temperature figures, degrees C per count
  // ---------------------------------------------------------------
  localparam logic [7:0] OT_HW_LIMIT = 8'hA0;
  localparam logic [7:0] RETRY_HYST = 8'h14;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 40000000;
  localparam int DETECT_TIME_MS = 20;
  localparam int DETECT_MAX_CYC = DETECT_TIME_MS * (CLK_HZ / 1000);
  localparam int FLT_LEN = 8;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_RUN,
    ST_OT_LATCH,
    ST_OT_RETRY
  } vtm_state_t;

endpackage

/* File: verilog/vtm_filter.sv */
// Persistence filter: a condition must hold for LEN samples to count
`timescale 1ns/1ps
`default_nettype none
module vtm_filter #(
  parameter int unsigned LEN = 8
) (
  input wire logic i_clk,  // Clock
  input wire logic i_rst,  // Synchronous reset, active high
  input wire logic i_ce,   // Clock enable
  input wire logic i_raw,  // Raw compare result
  output logic o_level     // Qualified condition
);
  localparam int CNT_W = $clog2(LEN + 1);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic level;
  } vtm_flt_st_t;

  vtm_flt_st_t st_reg;
  vtm_flt_st_t st_next;

  always_comb begin
    st_next = st_reg;
    if (!i_raw) begin
      // Release at once so that resume is not delayed
      st_next.cnt = '0;
      st_next.level = 1'b0;
    end else if (st_reg.cnt == CNT_W'(LEN - 1)) begin
      st_next.level = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg <= '0;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  assign o_level = st_reg.level;
endmodule // vtm_filter
`default_nettype wire

/* File: verilog/vtm_conv_fsm.sv */
// Conversion sequencer: start, stop, thermal latch-off and auto-retry
`timescale 1ns/1ps
`default_nettype none
module vtm_conv_fsm (
  input wire logic i_clk,        // Clock
  input wire logic i_rst,        // Synchronous reset, active high
  input wire logic i_ce,         // Clock enable
  input wire logic i_op_on,      // Operation enabled by host
  input wire logic i_op_on_wr,   // Host wrote operation on, pulse
  input wire logic i_latch_mode, // 1 latch-off, 0 auto-retry
  input wire logic i_vin_ge_on,  // Input at or above turn-on
  input wire logic i_vin_low,    // Input at or below turn-off
  input wire logic i_ot_fault,   // Over-temperature fault
  input wire logic i_ot_below,   // Temperature below fault limit
  input wire logic i_ot_cool,    // Temperature more than 20 C below limit
  input wire logic i_ov_fault,   // Input overvoltage fault
  output logic o_conv_en,        // Conversion running
  output logic o_pwr_en,         // Power stage enabled
  output logic o_ot_off          // Held off by over-temperature
);
  import vtm_pkg::*;

  typedef struct packed {
    vtm_state_t state;
  } vtm_fsm_st_t;

  vtm_fsm_st_t st_reg;
  vtm_fsm_st_t st_next;

  always_comb begin
    st_next = st_reg;
    case (st_reg.state)
      ST_OFF: begin
        if (i_op_on && i_vin_ge_on && !i_vin_low && !i_ot_fault) begin
          st_next.state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (i_ot_fault) begin
          st_next.state = i_latch_mode ? ST_OT_LATCH : ST_OT_RETRY;
        end else if (!i_op_on || i_vin_low) begin
          st_next.state = ST_OFF;
        end
      end
      ST_OT_LATCH: begin
        if (i_op_on_wr && i_ot_below) begin
          st_next.state = ST_OFF;
        end
      end
      ST_OT_RETRY: begin
        if (i_ot_cool) begin
          st_next.state = ST_OFF;
        end
      end
      default: begin
        st_next.state = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg <= '{state: ST_OFF};
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  assign o_conv_en = (st_reg.state == ST_RUN);
  assign o_pwr_en = (st_reg.state == ST_RUN) && !i_ov_fault;
  assign o_ot_off = (st_reg.state == ST_OT_LATCH) ||
                    (st_reg.state == ST_OT_RETRY);
endmodule // vtm_conv_fsm
`default_nettype wire

/* File: verilog/vtm_limit_monitor.sv */
// Limit registers, compare logic, flags and alert of the monitor
`timescale 1ns/1ps
`default_nettype none
module vtm_limit_monitor #(
  parameter int unsigned P_DETECT_MAX_CYC = vtm_pkg::DETECT_MAX_CYC
) (
  input wire logic i_clk,             // Clock, 40 MHz
  input wire logic i_rst,             // Synchronous reset, active high
  input wire logic i_ce,              // Clock enable, freezes all state
  input wire logic i_cmd_wr,          // Command write strobe
  input wire logic i_cmd_rd,          // Command read strobe
  input wire logic [7:0] i_cmd,       // Command code
  input wire logic [15:0] i_wdata,    // Write data word
  output logic [15:0] o_rdata,        // Read data word
  output logic o_ack,                 // Command accepted, pulse
  output logic o_nak,                 // Command unknown or not readable, pulse
  input wire logic [7:0] i_vin_meas,  // Input voltage, 250mV per count
  input wire logic [7:0] i_temp_meas, // Temperature, 1 C per count
  input wire logic [5:0] i_vin_on,    // Turn-on threshold, 250mV
  input wire logic i_ot_latch_mode,   // 1 latch-off, 0 auto-retry
  output logic o_conv_en,             // Conversion running
  output logic o_pwr_en,              // Power stage enabled
  output logic o_ot_off,              // Held off by over-temperature
  output logic [vtm_pkg::NFLAG-1:0] o_status, // Sticky status flags
  output logic o_alert_n              // Alert line, active low
);
  import vtm_pkg::*;

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  function automatic logic [2:0] reg_index(input logic [7:0] cmd);
    logic [2:0] idx;
    idx = IDX_NONE;
    case (cmd)
      CMD_INPUT_TURN_OFF_THRESHOLD: idx = IDX_INPUT_TURN_OFF_THRESHOLD;
      CMD_OT_FAULT: idx = IDX_OT_FAULT;
      CMD_OT_WARN: idx = IDX_OT_WARN;
      CMD_VIN_OV_FAULT: idx = IDX_OV_FAULT;
      CMD_VIN_OV_WARN: idx = IDX_OV_WARN;
      CMD_VIN_UV_WARN: idx = IDX_UV_WARN;
      default: idx = IDX_NONE;
    endcase
    return idx;
  endfunction

  function automatic logic [7:0] field_mask(input logic [2:0] idx);
    logic [7:0] m;
    m = MASK_VOLT;
    if (idx == IDX_OT_FAULT || idx == IDX_OT_WARN) begin
      m = MASK_TEMP;
    end
    return m;
  endfunction

  localparam int unsigned FLT_USE =
    (FLT_LEN < P_DETECT_MAX_CYC) ? FLT_LEN : P_DETECT_MAX_CYC;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [LIM_NUM-1:0][7:0] lim;
    logic [NFLAG-1:0] flags;
    logic op_on;
    logic [15:0] rdata;
    logic ack;
    logic nak;
    logic alert_n;
  } vtm_top_st_t;

  localparam vtm_top_st_t ST_RST = '{
    lim: RST_LIMS,
    flags: '0,
    op_on: OP_ON_RST,
    rdata: 16'h0000,
    ack: 1'b0,
    nak: 1'b0,
    alert_n: 1'b1
  };

  vtm_top_st_t st_reg;
  vtm_top_st_t st_next;

  logic [NCOND-1:0] raw;
  logic [NCOND-1:0] cond;
  logic [7:0] input_turn_off_threshold_thr;
  logic [7:0] ov_fault_thr;
  logic [7:0] ov_warn_thr;
  logic [7:0] uv_warn_thr;
  logic [7:0] vin_on_thr;
  logic [7:0] ot_eff;
  logic [8:0] temp_hyst;
  logic ot_below;
  logic ot_cool;
  logic op_on_wr;
  logic [2:0] acc_idx;

  // ---------------------------------------------------------------
  // Thresholds in measurement units
  // ---------------------------------------------------------------
  assign input_turn_off_threshold_thr = {2'h0, st_reg.lim[IDX_INPUT_TURN_OFF_THRESHOLD][5:0]};
  assign ov_fault_thr = {1'b0, st_reg.lim[IDX_OV_FAULT][5:0], 1'b0};
  assign ov_warn_thr = {1'b0, st_reg.lim[IDX_OV_WARN][5:0], 1'b0};
  assign uv_warn_thr = {2'h0, st_reg.lim[IDX_UV_WARN][5:0]};
  assign vin_on_thr = {2'h0, i_vin_on};

  // Programmed fault limit above the hardware ceiling is ignored
  assign ot_eff = (st_reg.lim[IDX_OT_FAULT] > OT_HW_LIMIT) ?
                  OT_HW_LIMIT : st_reg.lim[IDX_OT_FAULT];
  assign temp_hyst = {1'b0, i_temp_meas} + {1'b0, RETRY_HYST};
  assign ot_below = (i_temp_meas < ot_eff);
  assign ot_cool = (temp_hyst < {1'b0, ot_eff});

  // ---------------------------------------------------------------
  // Raw compares
  // ---------------------------------------------------------------
  always_comb begin
    raw = '0;
    if (st_reg.lim[IDX_OT_FAULT] > OT_HW_LIMIT) begin
      raw[FLG_OT_FAULT] = (i_temp_meas >= OT_HW_LIMIT);
    end else begin
      raw[FLG_OT_FAULT] = (i_temp_meas > ot_eff);
    end
    raw[FLG_OT_WARN] = (i_temp_meas > st_reg.lim[IDX_OT_WARN]);
    raw[FLG_OV_FAULT] = (i_vin_meas > ov_fault_thr);
    raw[FLG_OV_WARN] = (i_vin_meas > ov_warn_thr);
    raw[FLG_UV_WARN] = (i_vin_meas < uv_warn_thr);
    raw[CND_VIN_LOW] = (i_vin_meas <= input_turn_off_threshold_thr);
  end

  // ---------------------------------------------------------------
  // Qualification, no longer than the detection budget
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCOND; g++) begin : g_flt
      vtm_filter #(
        .LEN(FLT_USE)
      ) u_flt (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_raw(raw[g]),
        .o_level(cond[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Command port, limit registers and flags
  // ---------------------------------------------------------------
  assign acc_idx = reg_index(i_cmd);
  assign op_on_wr = i_cmd_wr && (i_cmd == CMD_OPERATION) &&
                    i_wdata[OP_ON_BIT];

  always_comb begin
    logic clr;
    clr = 1'b0;
    st_next = st_reg;
    st_next.ack = 1'b0;
    st_next.nak = 1'b0;
    if (i_cmd_wr) begin
      st_next.ack = 1'b1;
      if (acc_idx != IDX_NONE) begin
        // Upper bits of the word are dropped
        st_next.lim[acc_idx] = i_wdata[7:0] & field_mask(acc_idx);
      end else if (i_cmd == CMD_OPERATION) begin
        st_next.op_on = i_wdata[OP_ON_BIT];
      end else if (i_cmd == CMD_CLEAR_FAULTS) begin
        clr = 1'b1;
      end else begin
        st_next.ack = 1'b0;
        st_next.nak = 1'b1;
      end
    end else if (i_cmd_rd) begin
      st_next.ack = 1'b1;
      st_next.rdata = 16'h0000;
      if (acc_idx != IDX_NONE) begin
        st_next.rdata = {8'h00, st_reg.lim[acc_idx]};
      end else if (i_cmd == CMD_OPERATION) begin
        st_next.rdata = {8'h00, st_reg.op_on, 7'h00};
      end else begin
        st_next.ack = 1'b0;
        st_next.nak = 1'b1;
      end
    end
    // A condition present during a clear keeps its flag set
    st_next.flags = (st_reg.flags & ~{NFLAG{clr}}) |
                    cond[NFLAG-1:0];
    st_next.alert_n = ~|(st_next.flags & ALERT_MASK);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg <= ST_RST;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // Conversion sequencing
  // ---------------------------------------------------------------
  vtm_conv_fsm u_fsm (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_op_on(st_reg.op_on),
    .i_op_on_wr(op_on_wr),
    .i_latch_mode(i_ot_latch_mode),
    .i_vin_ge_on(i_vin_meas >= vin_on_thr),
    .i_vin_low(cond[CND_VIN_LOW]),
    .i_ot_fault(cond[FLG_OT_FAULT]),
    .i_ot_below(ot_below),
    .i_ot_cool(ot_cool),
    .i_ov_fault(cond[FLG_OV_FAULT]),
    .o_conv_en(o_conv_en),
    .o_pwr_en(o_pwr_en),
    .o_ot_off(o_ot_off)
  );

  assign o_rdata = st_reg.rdata;
  assign o_ack = st_reg.ack;
  assign o_nak = st_reg.nak;
  assign o_status = st_reg.flags;
  assign o_alert_n = st_reg.alert_n;
endmodule // vtm_limit_monitor
`default_nettype wire

/* File: sim/vtm_chk_monitor.sv */
// Port-level assertions of the limit monitor
`timescale 1ns/1ps
`default_nettype none
module vtm_chk_monitor #(
  parameter int unsigned P_DETECT_MAX_CYC = 8
) (
  input wire logic i_clk,             // Clock
  input wire logic i_rst,             // Reset
  input wire logic i_ce,              // Clock enable
  input wire logic i_cmd_wr,          // Write strobe
  input wire logic i_cmd_rd,          // Read strobe
  input wire logic [7:0] i_cmd,       // Command code
  input wire logic [15:0] i_wdata,    // Write word
  input wire logic [15:0] o_rdata,    // Read word
  input wire logic o_ack,             // Accepted
  input wire logic o_nak,             // Refused
  input wire logic [7:0] i_vin_meas,  // Input voltage
  input wire logic [7:0] i_temp_meas, // Temperature
  input wire logic [5:0] i_vin_on,    // Turn-on threshold
  input wire logic i_ot_latch_mode,   // Latch-off mode
  input wire logic o_conv_en,         // Conversion running
  input wire logic o_pwr_en,          // Power stage on
  input wire logic o_ot_off,          // Thermal hold-off
  input wire logic [vtm_pkg::NFLAG-1:0] o_status, // Flags
  input wire logic o_alert_n          // Alert, active low
);
  import vtm_pkg::*;
  logic op_wr_reg;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Marks an accepted switch-on command one cycle back
  always_ff @(posedge i_clk) begin
    op_wr_reg <= i_ce && i_cmd_wr && (i_cmd == CMD_OPERATION)
      && i_wdata[OP_ON_BIT];
  end
  AST_ACK_ONE: assert property ((i_ce && (i_cmd_wr || i_cmd_rd))
    |=> (o_ack ^ o_nak)) else $error("command not answered once");
  AST_NO_ACK: assert property ((i_ce && !i_cmd_wr && !i_cmd_rd)
    |=> !(o_ack || o_nak)) else $error("answer without command");
  AST_RD_HIGH: assert property ((i_ce && i_cmd_rd && !i_cmd_wr
    && (i_cmd == CMD_INPUT_TURN_OFF_THRESHOLD || i_cmd == CMD_VIN_UV_WARN))
    |=> (o_rdata[15:6] == 10'h000)) else $error("upper bits not zero");
  AST_ALERT_SET: assert property ((|(o_status & ALERT_MASK)) [*2]
    |-> !o_alert_n) else $error("alert not asserted");
  AST_ALERT_CLR: assert property ((!(|(o_status & ALERT_MASK))) [*2]
    |-> o_alert_n) else $error("alert without flag");
  AST_OT_OFF: assert property ((i_ce && i_temp_meas > 8'hA0) [*8]
    |-> ##[1:4] (!o_conv_en && o_status[FLG_OT_FAULT]))
    else $error("hot part keeps running");
  AST_VIN_LOW: assert property ((i_ce && i_vin_meas == 8'h00) [*8]
    |-> ##[1:4] !o_conv_en) else $error("runs on dead input");
  AST_START: assert property ($rose(o_conv_en)
    |-> ($past(i_vin_meas) >= {2'b00, $past(i_vin_on)}))
    else $error("start below turn-on");
  AST_LATCH: assert property (($fell(o_ot_off)
    && $past(i_ot_latch_mode)) |-> op_wr_reg)
    else $error("latch released without command");
  AST_PWR: assert property (o_pwr_en |-> o_conv_en)
    else $error("power stage on while stopped");
endmodule // vtm_chk_monitor
`default_nettype wire

/* File: sim/vtm_host_model.sv */
// Host-side command driver for the limit monitor
`timescale 1ns/1ps
`default_nettype none
module vtm_host_model (
  input wire logic i_clk,          // Clock
  output logic o_cmd_wr,           // Write strobe
  output logic o_cmd_rd,           // Read strobe
  output logic [7:0] o_cmd,        // Command code
  output logic [15:0] o_wdata,     // Write word
  input wire logic [15:0] i_rdata, // Read word
  input wire logic i_ack,          // Accepted
  input wire logic i_nak           // Refused
);
  initial begin
    o_cmd_wr = 1'b0;
    o_cmd_rd = 1'b0;
    o_cmd = 8'h00;
    o_wdata = 16'h0000;
  end
  // One command; idle code and data lines show the inverse of the last value, strobes go low
  task automatic xfer(input logic wr, input logic [7:0] c,
      input logic [15:0] d, output logic [15:0] q, output logic [1:0] an);
    @(negedge i_clk);
    o_cmd_wr = wr;
    o_cmd_rd = !wr;
    o_cmd = c;
    o_wdata = d;
    @(negedge i_clk);
    q = i_rdata;
    an = {i_ack, i_nak};
    o_cmd_wr = 1'b0;
    o_cmd_rd = 1'b0;
    o_cmd = ~c;
    o_wdata = ~d;
  endtask
endmodule // vtm_host_model
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench of the limit monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import vtm_pkg::*;
  localparam logic [7:0] CMDS [6] = '{CMD_INPUT_TURN_OFF_THRESHOLD, CMD_OT_FAULT,
    CMD_OT_WARN, CMD_VIN_OV_FAULT, CMD_VIN_OV_WARN, CMD_VIN_UV_WARN};
  localparam logic [15:0] RSTV [6] = '{16'h000B, 16'h0091, 16'h008C,
    16'h0020, 16'h001E, 16'h0028};
  logic i_clk, i_rst, i_ce, cmd_wr, cmd_rd, ack, nak, ot_latch;
  logic conv_en, pwr_en, ot_off, alert_n;
  logic [7:0] cmd, vin, temp;
  logic [5:0] vin_on;
  logic [15:0] wdata, rdata, q, d;
  logic [NFLAG-1:0] status;
  logic [1:0] an;
  logic [31:0] seed;
  int n_fail, cmp_count;
  vtm_limit_monitor #(.P_DETECT_MAX_CYC(8)) i_vtm_limit_monitor (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_cmd_wr(cmd_wr),
    .i_cmd_rd(cmd_rd), .i_cmd(cmd), .i_wdata(wdata), .o_rdata(rdata),
    .o_ack(ack), .o_nak(nak), .i_vin_meas(vin), .i_temp_meas(temp),
    .i_vin_on(vin_on), .i_ot_latch_mode(ot_latch), .o_conv_en(conv_en),
    .o_pwr_en(pwr_en), .o_ot_off(ot_off), .o_status(status),
    .o_alert_n(alert_n));
  vtm_host_model i_vtm_host_model (.i_clk(i_clk), .o_cmd_wr(cmd_wr),
    .o_cmd_rd(cmd_rd), .o_cmd(cmd), .o_wdata(wdata), .i_rdata(rdata),
    .i_ack(ack), .i_nak(nak));
  function automatic logic [15:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  function automatic logic [15:0] msk(int i);
    return (i == 1 || i == 2) ? 16'h00FF : 16'h003F;
  endfunction
  task automatic chk16(input logic [15:0] g, e, input string m);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk1(input logic g, e, input string m);
    chk16({15'h0000, g}, {15'h0000, e}, m);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] v);
    i_vtm_host_model.xfer(1'b1, c, v, q, an);
  endtask
  task automatic rd(input logic [7:0] c);
    i_vtm_host_model.xfer(1'b0, c, 16'h0000, q, an);
  endtask
  // Filter length 8 plus flag and state stages fit in 12 cycles
  task automatic meas(input logic [7:0] v, t);
    @(negedge i_clk);
    vin = v;
    temp = t;
    repeat (12) @(negedge i_clk);
  endtask
  task automatic do_reset();
    @(negedge i_clk);
    i_rst = 1'b1;
    repeat (4) @(negedge i_clk);
    i_rst = 1'b0;
  endtask
  task automatic clear(input string s);
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    repeat (2) @(negedge i_clk);
    chk16({11'h000, status}, 16'h0000, "flags cleared");
    chk1(alert_n, 1'b1, "alert released");
    $display("test %s done", s);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  initial begin
    repeat (6000) @(posedge i_clk);
    n_fail++;
    print_verdict();
  end
  initial begin
    seed = 32'h8BB4EC79;
    i_rst = 1'b1;
    i_ce = 1'b1;
    ot_latch = 1'b1;
    vin = 8'h0F;
    temp = 8'h19;
    vin_on = 6'h10;
    do_reset();
    for (int i = 0; i < 6; i++) begin
      rd(CMDS[i]);
      chk16(q, RSTV[i], "reset value");
    end
    rd(8'h60);
    chk1(an[0], 1'b1, "unknown command refused");
    repeat (3) for (int i = 0; i < 6; i++) begin
      d = xs();
      wr(CMDS[i], d);
      chk16({14'h0000, an}, 16'h0002, "write acknowledged");
      rd(CMDS[i]);
      chk16(q, d & msk(i), "masked write");
    end
    $display("test registers done");
    do_reset();
    meas(8'h0F, 8'h19);
    chk1(conv_en, 1'b0, "held below turn-on");
    meas(8'h30, 8'h19);
    chk1(conv_en, 1'b1, "started");
    clear("start-up");
    meas(8'h27, 8'h19);
    chk1(status[FLG_UV_WARN], 1'b1, "uv flag");
    chk1(alert_n, 1'b0, "uv alert");
    meas(8'h30, 8'h19);
    clear("undervoltage");
    meas(8'h3C, 8'h19);
    chk1(status[FLG_OV_WARN], 1'b0, "ov warn at limit");
    meas(8'h3D, 8'h19);
    chk1(status[FLG_OV_WARN], 1'b1, "ov warn");
    chk1(alert_n, 1'b0, "ov alert");
    meas(8'h41, 8'h19);
    chk1(status[FLG_OV_FAULT], 1'b1, "ov fault");
    chk1(pwr_en, 1'b0, "power stage off");
    meas(8'h30, 8'h19);
    chk1(pwr_en, 1'b1, "power stage back");
    clear("overvoltage");
    meas(8'h30, 8'h8D);
    chk1(status[FLG_OT_WARN], 1'b1, "ot warn");
    meas(8'h30, 8'hA1);
    chk1(status[FLG_OT_FAULT], 1'b1, "ot fault");
    chk1(conv_en, 1'b0, "ot stop");
    meas(8'h30, 8'h19);
    chk1(conv_en, 1'b0, "latched off");
    wr(CMD_OPERATION, 16'h0080);
    meas(8'h30, 8'h19);
    chk1(conv_en, 1'b1, "re-enabled");
    wr(CMD_OPERATION, 16'h0000);
    meas(8'h30, 8'h19);
    rd(CMD_OPERATION);
    chk16(q, 16'h0000, "operation off");
    chk1(conv_en, 1'b0, "stopped by host");
    wr(CMD_OPERATION, 16'h0080);
    meas(8'h30, 8'h19);
    rd(CMD_OPERATION);
    chk16(q, 16'h0080, "operation on");
    chk1(conv_en, 1'b1, "restarted by host");
    ot_latch = 1'b0;
    meas(8'h30, 8'hA1);
    chk1(ot_off, 1'b1, "retry hold");
    meas(8'h30, 8'h7D);
    chk1(conv_en, 1'b0, "not cool enough");
    meas(8'h30, 8'h7C);
    chk1(conv_en, 1'b1, "auto restart");
    wr(CMD_OT_FAULT, 16'h00C8);
    meas(8'h30, 8'h9F);
    chk1(conv_en, 1'b1, "below hard limit");
    meas(8'h30, 8'hA0);
    chk1(ot_off, 1'b1, "hard limit");
    meas(8'h30, 8'h19);
    clear("thermal");
    meas(8'h0C, 8'h19);
    chk1(conv_en, 1'b1, "above turn-off");
    meas(8'h0B, 8'h19);
    chk1(conv_en, 1'b0, "at turn-off");
    meas(8'h00, 8'h19);
    $display("test turn-off done");
    print_verdict();
  end
endmodule // tb_top
bind vtm_limit_monitor vtm_chk_monitor #(
  .P_DETECT_MAX_CYC(P_DETECT_MAX_CYC)) i_vtm_chk_monitor (
  .i_clk, .i_rst, .i_ce, .i_cmd_wr, .i_cmd_rd, .i_cmd, .i_wdata,
  .o_rdata, .o_ack, .o_nak, .i_vin_meas, .i_temp_meas, .i_vin_on,
  .i_ot_latch_mode, .o_conv_en, .o_pwr_en, .o_ot_off, .o_status,
  .o_alert_n);
`default_nettype wire
